// >>> pin_io_cell.sv
// pin input/output cell: delayed input, storage pairs, output and enable paths
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - pad through delay straight to input_direct
// - delayed pad also captured by input pair
// - output data muxed direct or stored, driven
// - enable lines muxed direct or stored
// - each path own pair, register or latch
// - pad, data, enable and gate inputs have absorbed inversion
// - input-only variant has no output logic
// - input pair shareable with adjacent cell
// - one pad serves input and output
module pin_io_cell #(
   parameter bit INPUT_ONLY = 1'b0,
   parameter int DELAY_TAPS = 15
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [pin_io_pkg::ADDR_W-1:0] addr,
   input wire logic [pin_io_pkg::DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [pin_io_pkg::DATA_W-1:0] rdata,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic input_direct,
   output logic registered_input_first,
   output logic registered_input_second,
   input wire pin_io_pkg::pair_t gate_in,
   input wire logic output_data_first,
   input wire logic output_data_second,
   input wire pin_io_pkg::pair_t gate_out,
   input wire logic output_enable_first,
   input wire logic output_enable_second,
   input wire pin_io_pkg::pair_t gate_oe,
   input wire logic output_phase,
   input wire pin_io_pkg::pair_t share_in,
   output pin_io_pkg::pair_t share_out
);
   // reset release
   logic [1:0] rst_sync_reg;
   logic [1:0] rst_sync_next;
   logic rst_n;

   always_comb begin
      rst_sync_next = {rst_sync_reg[0], 1'b1};
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= pin_io_pkg::SYNC_RST;
      end else begin
         rst_sync_reg <= rst_sync_next;
      end
   end

   assign rst_n = rst_sync_reg[1];

   // configuration and read port
   pin_io_pkg::cfg_t cfg_reg;
   pin_io_pkg::cfg_t cfg_next;
   logic [pin_io_pkg::DATA_W-1:0] rdata_reg;
   logic [pin_io_pkg::DATA_W-1:0] rdata_next;
   logic [pin_io_pkg::STAT_W-1:0] status;

   always_comb begin
      cfg_next = cfg_reg;
      // a frozen clock enable keeps the read word as well
      rdata_next = ce ? '0 : rdata_reg;
      if (ce && wr_en && addr == pin_io_pkg::CFG_ADDR) begin
         cfg_next = pin_io_pkg::cfg_t'(wdata[pin_io_pkg::CFG_W-1:0]);
      end
      if (ce && rd_en) begin
         unique case (addr)
            pin_io_pkg::CFG_ADDR: rdata_next = {{(pin_io_pkg::DATA_W-pin_io_pkg::CFG_W){1'b0}},
                                               cfg_reg};
            pin_io_pkg::STAT_ADDR: rdata_next = {{(pin_io_pkg::DATA_W-pin_io_pkg::STAT_W){1'b0}},
                                                status};
            default: rdata_next = '0;
         endcase
      end
   end

   // read data stand one cycle while ce is high, so a strobe-free enabled cycle clears them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= pin_io_pkg::CFG_RST;
         rdata_reg <= '0;
      end else begin
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // pad synchroniser and programmable delay line
   logic [1:0] pad_sync_reg;
   logic [1:0] pad_sync_next;
   logic [DELAY_TAPS:0] tap;
   logic delayed_in;

   always_comb begin
      pad_sync_next = pad_sync_reg;
      if (ce) begin
         pad_sync_next = {pad_sync_reg[0], pad_in};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_sync_reg <= pin_io_pkg::SYNC_RST;
      end else begin
         pad_sync_reg <= pad_sync_next;
      end
   end

   // tap 0 is the undelayed synchronised pad; each stage adds one cycle
   assign tap[0] = pad_sync_reg[1] ^ cfg_reg.inv_pad;

   genvar g;
   generate
      for (g = 1; g <= DELAY_TAPS; g++) begin : g_delay
         logic stage_reg;
         logic stage_next;
         always_comb begin
            stage_next = ce ? tap[g-1] : stage_reg;
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_reg <= 1'b0;
            end else begin
               stage_reg <= stage_next;
            end
         end
         assign tap[g] = stage_reg;
      end
   endgenerate

   // taps beyond the built line fall back to the longest one
   assign delayed_in = (int'(cfg_reg.in_delay) > DELAY_TAPS) ? tap[DELAY_TAPS] :
                       tap[cfg_reg.in_delay];
   assign input_direct = delayed_in;

   // input storage pair, exported to the neighbour
   pin_io_pkg::pair_t gate_in_eff;
   pin_io_pkg::pair_t in_q;

   assign gate_in_eff = gate_in ^ {2{cfg_reg.inv_gate}};

   storage_pair u_in_pair (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .latch_mode(cfg_reg.in_latch),
      .gate(gate_in_eff),
      .d({delayed_in, delayed_in}),
      .q(in_q)
   );

   assign share_out = in_q;
   // shared use only helps when the neighbour's pair is gated the same way
   assign registered_input_first = cfg_reg.share_use ? share_in.first : in_q.first;
   assign registered_input_second = cfg_reg.share_use ? share_in.second : in_q.second;

   // output and enable paths
   logic oe_sel;

   generate
      if (INPUT_ONLY) begin : g_in_only
         assign pad_out = 1'b0;
         assign pad_oe = 1'b0;
         assign oe_sel = 1'b1;

         property p_input_only_quiet;
            @(posedge clk) disable iff (!rst_n)
            1'b1 |-> (!pad_oe && !pad_out);
         endproperty
         a_input_only_quiet: assert property (p_input_only_quiet)
            else $error("input-only cell drives its pad");
      end else begin : g_full
         pin_io_pkg::pair_t out_d;
         pin_io_pkg::pair_t oe_d;
         pin_io_pkg::pair_t out_q;
         pin_io_pkg::pair_t oe_q;
         logic out_sel;

         assign out_d = {output_data_second ^ cfg_reg.inv_o2,
                         output_data_first ^ cfg_reg.inv_o1};
         assign oe_d = {output_enable_second ^ cfg_reg.inv_t2,
                        output_enable_first ^ cfg_reg.inv_t1};

         storage_pair u_out_pair (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .latch_mode(cfg_reg.out_latch),
            .gate(gate_out ^ {2{cfg_reg.inv_gate}}),
            .d(out_d),
            .q(out_q)
         );

         storage_pair u_oe_pair (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .latch_mode(cfg_reg.oe_latch),
            .gate(gate_oe ^ {2{cfg_reg.inv_gate}}),
            .d(oe_d),
            .q(oe_q)
         );

         // output_phase picks the first or second line, as a ddr output mux
         always_comb begin
            if (cfg_reg.out_store) begin
               out_sel = output_phase ? out_q.second : out_q.first;
            end else begin
               out_sel = output_phase ? out_d.second : out_d.first;
            end
            if (cfg_reg.oe_store) begin
               oe_sel = output_phase ? oe_q.second : oe_q.first;
            end else begin
               oe_sel = output_phase ? oe_d.second : oe_d.first;
            end
         end

         assign pad_out = out_sel;
         assign pad_oe = !oe_sel;

         property p_out_direct;
            @(posedge clk) disable iff (!rst_n)
            (!cfg_reg.out_store && !output_phase) |->
               (pad_out == (output_data_first ^ cfg_reg.inv_o1));
         endproperty
         a_out_direct: assert property (p_out_direct)
            else $error("direct output path does not follow first line");

         property p_out_inverted;
            @(posedge clk) disable iff (!rst_n)
            (!cfg_reg.out_store && output_phase && cfg_reg.inv_o2) |->
               (pad_out != output_data_second);
         endproperty
         a_out_inverted: assert property (p_out_inverted)
            else $error("selected output inversion not applied");

         logic gate_eff_first;
         assign gate_eff_first = gate_oe.first ^ cfg_reg.inv_gate;

         property p_oe_stored;
            @(posedge clk) disable iff (!rst_n)
            (ce && !cfg_reg.oe_latch && gate_eff_first && $stable(cfg_reg)) ##1
               (cfg_reg.oe_store && !output_phase && !gate_eff_first) |->
               (pad_oe == !$past(oe_d.first));
         endproperty
         a_oe_stored: assert property (p_oe_stored)
            else $error("stored enable path lost captured value");

         property p_oe_tristate;
            @(posedge clk) disable iff (!rst_n)
            (!cfg_reg.oe_store && !output_phase && (output_enable_first ^ cfg_reg.inv_t1)) |->
               !pad_oe;
         endproperty
         a_oe_tristate: assert property (p_oe_tristate)
            else $error("driver enabled while enable line asserted");

         c_bidir_turn: cover property (@(posedge clk) disable iff (!rst_n)
            pad_oe ##1 !pad_oe ##[1:4] pad_oe);
         c_stored_out: cover property (@(posedge clk) disable iff (!rst_n)
            cfg_reg.out_store && output_phase && pad_oe);
      end
   endgenerate

   // pad reads back through the input path in both directions
   assign status = {oe_sel, pad_oe, pad_out, in_q.second, in_q.first, delayed_in};

   property p_direct_input;
      @(posedge clk) disable iff (!rst_n)
      // synchroniser holds reset zeros for two edges after release
      ($past(rst_n, 2) && $past(ce, 1) && $past(ce, 2) && cfg_reg.in_delay == 4'h0) |->
         (input_direct == ($past(pad_in, 2) ^ cfg_reg.inv_pad));
   endproperty
   a_direct_input: assert property (p_direct_input)
      else $error("direct input not pad delayed by synchroniser");

   property p_reg_input;
      @(posedge clk) disable iff (!rst_n)
      (ce && gate_in_eff.first && !cfg_reg.in_latch && !cfg_reg.share_use) ##1
         (!cfg_reg.share_use && !gate_in_eff.first) |->
         (registered_input_first == $past(delayed_in));
   endproperty
   a_reg_input: assert property (p_reg_input)
      else $error("registered input did not capture delayed pad");

   property p_share;
      @(posedge clk) disable iff (!rst_n)
      cfg_reg.share_use |->
         (registered_input_first == share_in.first && registered_input_second == share_in.second);
   endproperty
   a_share: assert property (p_share)
      else $error("shared pair not used for registered inputs");

   property p_pad_inverted;
      @(posedge clk) disable iff (!rst_n)
      ($past(rst_n, 2) && $past(ce, 1) && $past(ce, 2) && cfg_reg.in_delay == 4'h0 &&
         cfg_reg.inv_pad) |->
         (input_direct != $past(pad_in, 2));
   endproperty
   a_pad_inverted: assert property (p_pad_inverted)
      else $error("pad inversion not applied on input");

   c_delay_used: cover property (@(posedge clk) disable iff (!rst_n)
      cfg_reg.in_delay != 4'h0 && input_direct);
   c_latch_in: cover property (@(posedge clk) disable iff (!rst_n)
      cfg_reg.in_latch && gate_in_eff.first);
endmodule : pin_io_cell

// >>> pin_io_pkg.sv
// shared constants and carrier types for the pin input/output cell
package pin_io_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CFG_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h4;
   localparam int DELAY_W = 4;
   localparam int CFG_W = 17;
   localparam int STAT_W = 6;
   localparam logic [CFG_W-1:0] CFG_RST = 17'h00000;
   localparam logic [1:0] SYNC_RST = 2'h0;

   // two storage elements of one path, or their two gates
   typedef struct packed {
      logic second;
      logic first;
   } pair_t;

   // configuration word, bit 0 is in_store
   typedef struct packed {
      logic [DELAY_W-1:0] in_delay;
      logic inv_gate;
      logic inv_t2;
      logic inv_t1;
      logic inv_o2;
      logic inv_o1;
      logic inv_pad;
      logic share_use;
      logic oe_latch;
      logic out_latch;
      logic in_latch;
      logic oe_store;
      logic out_store;
      logic in_store;
   } cfg_t;
endpackage : pin_io_pkg

// >>> storage_pair.sv
// pair of storage elements, each a register or a transparent latch
`timescale 1ns/100ps
module storage_pair (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic latch_mode,
   input wire pin_io_pkg::pair_t gate,
   input wire pin_io_pkg::pair_t d,
   output pin_io_pkg::pair_t q
);
   pin_io_pkg::pair_t q_reg;
   pin_io_pkg::pair_t q_next;

   always_comb begin
      q_next = q_reg;
      if (ce && gate.first) begin
         q_next.first = d.first;
      end
      if (ce && gate.second) begin
         q_next.second = d.second;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   // latch mode passes d while the gate is open and holds it after closing
   assign q.first = (latch_mode && ce && gate.first) ? d.first : q_reg.first;
   assign q.second = (latch_mode && ce && gate.second) ? d.second : q_reg.second;

   property p_latch_transparent;
      @(posedge clk) disable iff (!rst_n)
      (latch_mode && ce && gate.first) |-> (q.first == d.first);
   endproperty
   a_latch_transparent: assert property (p_latch_transparent)
      else $error("latch element not transparent while gate open");

   property p_register_holds;
      @(posedge clk) disable iff (!rst_n)
      (!latch_mode && ce && gate.second) ##1 !latch_mode |-> (q.second == $past(d.second));
   endproperty
   a_register_holds: assert property (p_register_holds)
      else $error("register element did not capture on its gate");
endmodule : storage_pair

// >>> pad_partner.sv
// far-side model of the circuitry sharing the package pad with the cell
`timescale 1ns/100ps
module pad_partner (
   input wire logic clk,
   input wire logic pad_out,
   input wire logic pad_oe,
   input wire logic ext_en,
   input wire logic ext_lvl,
   output logic pad_level
);
   logic float_reg = 1'b0;
   // an undriven pad wanders, so a stale value can never pass for a real one
   always @(posedge clk) begin
      float_reg <= ~float_reg;
   end
   // both parties driving is contention: unknown level
   always_comb begin
      if (pad_oe && ext_en) begin
         pad_level = 1'bx;
      end else if (pad_oe) begin
         pad_level = pad_out;
      end else if (ext_en) begin
         pad_level = ext_lvl;
      end else begin
         pad_level = float_reg;
      end
   end
endmodule : pad_partner

// >>> pin_io_cell_tb_top.sv
// self-checking bench for the pin input/output cell
`timescale 1ns/100ps
module pin_io_cell_tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
   logic od1 = 1'b0, od2 = 1'b0, oen1 = 1'b1, oen2 = 1'b1, phase = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd_v, c, seed = 32'h837b;
   logic pad_in, pad_out, pad_oe, oe_io, input_direct, rin1, rin2, e1, e2, sel;
   pin_io_pkg::pair_t gate_in = 2'h0, gate_out = 2'h0, gate_oe = 2'h0, share_in = 2'h0;
   pin_io_pkg::pair_t share_out;
   int failures = 0, cmp_count = 0, cycles = 0;

   pin_io_cell #(.INPUT_ONLY(1'b0), .DELAY_TAPS(15)) DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .input_direct(input_direct),
      .registered_input_first(rin1), .registered_input_second(rin2), .gate_in(gate_in),
      .output_data_first(od1), .output_data_second(od2), .gate_out(gate_out),
      .output_enable_first(oen1), .output_enable_second(oen2), .gate_oe(gate_oe),
      .output_phase(phase), .share_in(share_in), .share_out(share_out));
   pin_io_cell #(.INPUT_ONLY(1'b1), .DELAY_TAPS(15)) DUT_IN (.clk(clk), .arst_n(arst_n),
      .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(),
      .pad_in(pad_in), .pad_out(), .pad_oe(oe_io), .input_direct(),
      .registered_input_first(), .registered_input_second(), .gate_in(gate_in),
      .output_data_first(od1), .output_data_second(od2), .gate_out(gate_out),
      .output_enable_first(oen1), .output_enable_second(oen2), .gate_oe(gate_oe),
      .output_phase(phase), .share_in(share_in), .share_out());
   pad_partner PAD (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
      .ext_lvl(ext_lvl), .pad_level(pad_in));

   always #20 clk = ~clk;

   task automatic conclude();
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         conclude();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
   endfunction : xs

   function automatic logic pick(input logic ph, input logic a, input logic b);
      pick = ph ? b : a;
   endfunction : pick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd

   initial begin
      cyc(3);
      arst_n <= 1'b1;
      cyc(3);
      rd(pin_io_pkg::CFG_ADDR, rd_v);
      chk(rd_v, 32'h0);
      @(posedge clk);
      ce <= 1'b0;
      wr(pin_io_pkg::CFG_ADDR, 32'h1ff);
      ce <= 1'b1;
      rd(pin_io_pkg::CFG_ADDR, rd_v);
      chk(rd_v, 32'h0);
      rd(4'h8, rd_v);
      chk(rd_v, 32'h0);
      // direct output and enable paths under random inversions
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         c = {15'h0, seed[16:0] & 17'h1fff9};
         wr(pin_io_pkg::CFG_ADDR, c);
         rd(pin_io_pkg::CFG_ADDR, rd_v);
         chk(rd_v, c);
         @(posedge clk);
         {phase, oen2, oen1, od2, od1} <= seed[24:20];
         @(negedge clk);
         sel = pick(seed[24], seed[22] ^ c[10], seed[23] ^ c[11]);
         chk(pad_out, pick(seed[24], seed[20] ^ c[8], seed[21] ^ c[9]));
         chk(pad_oe, !sel);
         chk(oe_io, 1'b0);
         rd(pin_io_pkg::STAT_ADDR, rd_v);
         chk(rd_v[5:3], {sel, !sel, pad_out});
      end
      // programmable delay, boundary 15 included, with pad inversion
      for (int i = 0; i < 4; i++) begin
         wr(pin_io_pkg::CFG_ADDR, {15'h0, 4'(i * 5), 13'h0080});
         oen1 <= 1'b1;
         phase <= 1'b0;
         ext_en <= 1'b1;
         ext_lvl <= 1'b0;
         cyc(20);
         ext_lvl <= 1'b1;
         cyc(1 + i * 5);
         @(negedge clk);
         chk(input_direct, 1'b1);
         cyc(1);
         @(negedge clk);
         chk(input_direct, 1'b0);
      end
      // input pair in register mode, gates picked at random
      wr(pin_io_pkg::CFG_ADDR, 32'h0);
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         @(posedge clk);
         ext_lvl <= seed[0];
         cyc(2);
         gate_in <= (i == 0) ? 2'h3 : seed[2:1];
         cyc(1);
         gate_in <= 2'h0;
         ext_lvl <= ~seed[0];
         if (i == 0 || seed[1]) e1 = seed[0];
         if (i == 0 || seed[2]) e2 = seed[0];
         @(negedge clk);
         chk({rin2, rin1}, {e2, e1});
         chk(share_out, {e2, e1});
      end
      // latch mode: transparent while open, holds when closed
      wr(pin_io_pkg::CFG_ADDR, 32'h8);
      ext_lvl <= 1'b0;
      cyc(3);
      gate_in <= 2'h3;
      ext_lvl <= 1'b1;
      cyc(2);
      @(negedge clk);
      chk({rin2, rin1}, 2'h3);
      cyc(2);
      gate_in <= 2'h0;
      ext_lvl <= 1'b0;
      cyc(4);
      @(negedge clk);
      chk({rin2, rin1}, 2'h3);
      // neighbour pair routed to the registered inputs
      wr(pin_io_pkg::CFG_ADDR, 32'h40);
      share_in <= 2'h2;
      cyc(2);
      @(negedge clk);
      chk({rin2, rin1}, 2'h2);
      // stored output and enable pairs
      for (int i = 0; i < 8; i++) begin
         wr(pin_io_pkg::CFG_ADDR, {26'h0, i[0], i[0], 4'h6});
         ext_en <= 1'b0;
         seed = xs(seed);
         {oen2, oen1, od2, od1} <= seed[3:0];
         gate_out <= 2'h3;
         gate_oe <= 2'h3;
         cyc(1);
         gate_out <= 2'h0;
         gate_oe <= 2'h0;
         {oen2, oen1, od2, od1} <= ~seed[3:0];
         phase <= seed[4];
         @(negedge clk);
         chk(pad_out, pick(seed[4], seed[0], seed[1]));
         chk(pad_oe, !pick(seed[4], seed[2], seed[3]));
      end
      // driving the shared pad loops back through the input path
      wr(pin_io_pkg::CFG_ADDR, 32'h0);
      {phase, oen1, od1} <= 3'h1;
      cyc(4);
      @(negedge clk);
      chk({pad_oe, input_direct}, 2'h3);
      conclude();
   end
endmodule : pin_io_cell_tb_top
